// ---- design/fan_monitor_pkg.sv ----
// Constants and types shared by the fan speed monitor
package fan_monitor_pkg;

  // Timing
  localparam int unsigned MCLK_HZ  = 100_000_000;
  localparam int unsigned TICK_HZ  = 100_000;
  localparam int unsigned TICK_DIV = MCLK_HZ / TICK_HZ;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] HIGH_OFF = 8'h08;
  localparam logic [7:0] LOW_OFF  = 8'h0C;

  // Control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_BIT   = 1;
  localparam int CTRL_EDGES_LSB  = 11;
  localparam int CTRL_CR_IE_BIT  = 14;
  localparam int CTRL_TG_IE_BIT  = 15;
  localparam int CTRL_COUNT_LSB  = 16;

  // Status fields
  localparam int STAT_OOL_BIT = 0;
  localparam int STAT_TG_BIT  = 1;
  localparam int STAT_PIN_BIT = 2;
  localparam int STAT_CR_BIT  = 3;

  // Reset values and the counter ceiling
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] HIGH_RST  = 16'hFFFF;
  localparam logic [15:0] LOW_RST   = 16'h0000;
  localparam logic [1:0]  EDGES_RST = 2'h0;

  // Edge-count field codes
  localparam logic [1:0] EDGES_2 = 2'h0;
  localparam logic [1:0] EDGES_3 = 2'h1;
  localparam logic [1:0] EDGES_5 = 2'h2;
  localparam logic [1:0] EDGES_9 = 2'h3;

  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_ARMED,
    MEAS_RUN
  } meas_state_e;

  // Number of edges that closes one interval
  function automatic logic [3:0] edges_needed(input logic [1:0] sel);
    logic [3:0] n;
    n = 4'h2;
    case (sel)
      EDGES_2: n = 4'h2;
      EDGES_3: n = 4'h3;
      EDGES_5: n = 4'h5;
      EDGES_9: n = 4'h9;
      default: n = 4'h2;
    endcase
    return n;
  endfunction : edges_needed

endpackage : fan_monitor_pkg

// ---- design/bit_sync.sv ----
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module bit_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } sync_s;

  sync_s q;
  sync_s d;

  always_comb begin
    d        = q;
    d.meta   = din;
    d.stable = q.meta;
    if (rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.stable;
endmodule : bit_sync

// ---- design/tick_gen.sv ----
// Divider that gives one-cycle pulses at the measurement rate
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned DIV = 1000
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  initial begin
    if (DIV < 2) $error("tick_gen: DIV must be at least 2");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tick_s;

  tick_s q;
  tick_s d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == W'(DIV - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
    if (rst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign tick = q.tick;
endmodule : tick_gen

// ---- design/fan_speed_monitor.sv ----
// Fan speed monitor with APB register access
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module fan_speed_monitor #(
  parameter int unsigned TICK_DIV = fan_monitor_pkg::TICK_DIV
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        FAN_SPEED_IN,
  input  wire logic        SLEEP_REQ,
  output logic             SLEEP_ACK,
  output logic             IRQ
);

  initial begin
    if (TICK_DIV < 2) $error("fan_speed_monitor: TICK_DIV must be at least 2");
  end

  typedef struct packed {
    fan_monitor_pkg::meas_state_e st;
    logic [15:0] cnt;
    logic [15:0] reading;
    logic [3:0]  edges_seen;
    logic        fan_prev;
    logic        en;
    logic        mode;
    logic        cr_ie;
    logic        tg_ie;
    logic [1:0]  edge_sel;
    logic [15:0] hi;
    logic [15:0] lo;
    logic        ool;
    logic        tg;
    logic        cr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        sleep_ack;
  } mon_s;

  mon_s q;
  mon_s d;

  logic        fan_s;
  logic        tick;
  logic        rise;
  logic        any_edge;
  logic        run;
  logic        latch;
  logic        edge_done;
  logic        stall;
  logic [15:0] latch_val;
  logic [3:0]  need;
  logic        access;
  logic        done;
  logic        wr;
  logic        hit;
  logic [31:0] rdata;
  logic        clr_ool;
  logic        clr_tg;
  logic        clr_cr;

  // Fan pin is asynchronous to MCLK
  bit_sync fan_sync_i (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .din  (FAN_SPEED_IN),
    .dout (fan_s)
  );

  // Measurement time base; 16 bits of 10 us cover 655 ms, enough for 100 RPM
  tick_gen #(
    .DIV (TICK_DIV)
  ) tick_i (
    .clk  (MCLK),
    .rst  (SYS_RST),
    .tick (tick)
  );

  always_comb begin
    d          = q;
    rise       = fan_s & ~q.fan_prev;
    any_edge   = fan_s ^ q.fan_prev;
    d.fan_prev = fan_s;
    run        = q.en & ~SLEEP_REQ;
    need       = fan_monitor_pkg::edges_needed(q.edge_sel);
    latch      = 1'b0;
    edge_done  = 1'b0;
    stall      = 1'b0;
    latch_val  = q.cnt;

    // Counting engine
    if (!run) begin
      d.st         = fan_monitor_pkg::MEAS_IDLE;
      d.edges_seen = '0;
    end else if (!q.mode) begin
      d.st = fan_monitor_pkg::MEAS_IDLE;
      if (rise) begin
        d.cnt     = q.cnt + 16'h0001;
        latch     = 1'b1;
        latch_val = d.cnt;
      end
    end else begin
      case (q.st)
        fan_monitor_pkg::MEAS_IDLE: begin
          d.cnt        = fan_monitor_pkg::COUNT_RST;
          d.edges_seen = '0;
          d.st         = fan_monitor_pkg::MEAS_ARMED;
        end
        fan_monitor_pkg::MEAS_ARMED: begin
          // First edge opens the interval
          if (any_edge) begin
            d.cnt        = fan_monitor_pkg::COUNT_RST;
            d.edges_seen = 4'h1;
            d.st         = fan_monitor_pkg::MEAS_RUN;
          end
        end
        fan_monitor_pkg::MEAS_RUN: begin
          if (any_edge && (q.edges_seen == need - 4'h1)) begin
            edge_done    = 1'b1;
            latch        = 1'b1;
            latch_val    = q.cnt;
            d.cnt        = fan_monitor_pkg::COUNT_RST;
            d.edges_seen = 4'h1;
          end else if (tick && (q.cnt == fan_monitor_pkg::COUNT_MAX)) begin
            stall        = 1'b1;
            latch        = 1'b1;
            latch_val    = fan_monitor_pkg::COUNT_MAX;
            d.cnt        = fan_monitor_pkg::COUNT_RST;
            d.edges_seen = '0;
            d.st         = fan_monitor_pkg::MEAS_ARMED;
          end else begin
            if (any_edge) begin
              d.edges_seen = q.edges_seen + 4'h1;
            end
            if (tick) begin
              d.cnt = q.cnt + 16'h0001;
            end
          end
        end
        default: begin
          d.st = fan_monitor_pkg::MEAS_IDLE;
        end
      endcase
    end

    if (latch) begin
      d.reading = latch_val;
    end

    // APB slave, one wait state
    access    = PSEL & PENABLE;
    done      = access & q.pready;
    wr        = done & PWRITE;
    d.pready  = access & ~q.pready;
    hit       = (PADDR == fan_monitor_pkg::CTRL_OFF) || (PADDR == fan_monitor_pkg::STAT_OFF) ||
                (PADDR == fan_monitor_pkg::HIGH_OFF) || (PADDR == fan_monitor_pkg::LOW_OFF);
    rdata     = '0;
    case (PADDR)
      fan_monitor_pkg::CTRL_OFF: begin
        rdata[fan_monitor_pkg::CTRL_COUNT_LSB +: 16] = q.reading;
        rdata[fan_monitor_pkg::CTRL_TG_IE_BIT]       = q.tg_ie;
        rdata[fan_monitor_pkg::CTRL_CR_IE_BIT]       = q.cr_ie;
        rdata[fan_monitor_pkg::CTRL_EDGES_LSB +: 2]  = q.edge_sel;
        rdata[fan_monitor_pkg::CTRL_MODE_BIT]        = q.mode;
        rdata[fan_monitor_pkg::CTRL_ENABLE_BIT]      = q.en;
      end
      fan_monitor_pkg::STAT_OFF: begin
        rdata[fan_monitor_pkg::STAT_OOL_BIT] = q.ool;
        rdata[fan_monitor_pkg::STAT_TG_BIT]  = q.tg;
        rdata[fan_monitor_pkg::STAT_PIN_BIT] = fan_s;
        rdata[fan_monitor_pkg::STAT_CR_BIT]  = q.cr;
      end
      fan_monitor_pkg::HIGH_OFF: rdata[15:0] = q.hi;
      fan_monitor_pkg::LOW_OFF:  rdata[15:0] = q.lo;
      default:                   rdata       = '0;
    endcase
    if (d.pready) begin
      d.prdata  = PWRITE ? 32'h0000_0000 : rdata;
      d.pslverr = ~hit;
    end else begin
      d.pslverr = 1'b0;
    end

    clr_ool = 1'b0;
    clr_tg  = 1'b0;
    clr_cr  = 1'b0;
    if (wr) begin
      case (PADDR)
        fan_monitor_pkg::CTRL_OFF: begin
          d.tg_ie    = PWDATA[fan_monitor_pkg::CTRL_TG_IE_BIT];
          d.cr_ie    = PWDATA[fan_monitor_pkg::CTRL_CR_IE_BIT];
          d.edge_sel = PWDATA[fan_monitor_pkg::CTRL_EDGES_LSB +: 2];
          d.mode     = PWDATA[fan_monitor_pkg::CTRL_MODE_BIT];
          d.en       = PWDATA[fan_monitor_pkg::CTRL_ENABLE_BIT];
        end
        fan_monitor_pkg::STAT_OFF: begin
          clr_ool = PWDATA[fan_monitor_pkg::STAT_OOL_BIT];
          clr_tg  = PWDATA[fan_monitor_pkg::STAT_TG_BIT];
          clr_cr  = PWDATA[fan_monitor_pkg::STAT_CR_BIT];
        end
        fan_monitor_pkg::HIGH_OFF: d.hi = PWDATA[15:0];
        fan_monitor_pkg::LOW_OFF:  d.lo = PWDATA[15:0];
        default: begin
        end
      endcase
    end

    // Sticky flags; a new event beats a clear in the same cycle
    d.ool = (q.ool & ~clr_ool) |
            (latch & ((latch_val > q.hi) || (latch_val < q.lo)));
    d.tg  = (q.tg & ~clr_tg) | (run & any_edge);
    d.cr  = (q.cr & ~clr_cr) | (latch & q.mode);

    d.irq       = d.ool | (d.cr & d.cr_ie) | (d.tg & d.tg_ie);
    d.sleep_ack = SLEEP_REQ & (d.st == fan_monitor_pkg::MEAS_IDLE);

    if (SYS_RST) begin
      d          = '0;
      d.st       = fan_monitor_pkg::MEAS_IDLE;
      d.cnt      = fan_monitor_pkg::COUNT_RST;
      d.reading  = fan_monitor_pkg::COUNT_RST;
      d.edge_sel = fan_monitor_pkg::EDGES_RST;
      d.hi       = fan_monitor_pkg::HIGH_RST;
      d.lo       = fan_monitor_pkg::LOW_RST;
    end
  end

  always_ff @(posedge MCLK) begin
    q <= d;
  end

  assign PRDATA    = q.prdata;
  assign PREADY    = q.pready;
  assign PSLVERR   = q.pslverr;
  assign SLEEP_ACK = q.sleep_ack;
  assign IRQ       = q.irq;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence apb_setup_s;
    PSEL && !PENABLE;
  endsequence

  sequence apb_access_s;
    PSEL && PENABLE && !PREADY;
  endsequence

  apb_ready_a: assert property (apb_setup_s ##1 apb_access_s |=> PREADY)
    else $error("no ready one cycle into access");

  apb_error_a: assert property (apb_setup_s ##1 (apb_access_s && !hit) |=> PREADY && PSLVERR)
    else $error("unmapped address not refused");

  mode0_count_a: assert property (run && !q.mode && rise |=>
    q.cnt == $past(q.cnt) + 16'h0001)
    else $error("mode 0 counter missed a rising edge");

  mode0_reading_a: assert property (run && !q.mode && rise |=> q.reading == q.cnt)
    else $error("mode 0 reading did not follow the counter");

  mode0_wrap_a: assert property (run && !q.mode && rise && q.cnt == 16'hFFFF |=>
    q.cnt == 16'h0000)
    else $error("mode 0 counter did not wrap");

  mode1_tick_a: assert property (run && q.mode && q.st == fan_monitor_pkg::MEAS_RUN &&
    tick && !any_edge && q.cnt != 16'hFFFF |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("mode 1 counter missed a tick");

  edge_latch_a: assert property (edge_done |=>
    q.cnt == 16'h0000 && q.cr && q.reading == $past(q.cnt))
    else $error("edge interval did not latch and clear");

  // Decode checked against the field codes, not against the helper function
  edge_count_a: assert property (edge_done |->
    (q.edge_sel == fan_monitor_pkg::EDGES_2 && q.edges_seen == 4'h1) ||
    (q.edge_sel == fan_monitor_pkg::EDGES_3 && q.edges_seen == 4'h2) ||
    (q.edge_sel == fan_monitor_pkg::EDGES_5 && q.edges_seen == 4'h4) ||
    (q.edge_sel == fan_monitor_pkg::EDGES_9 && q.edges_seen == 4'h8))
    else $error("interval closed at wrong edge count");

  stall_latch_a: assert property (stall |=>
    q.reading == 16'hFFFF && q.st == fan_monitor_pkg::MEAS_ARMED)
    else $error("stalled fan not reported");

  limit_high_a: assert property (latch && latch_val > q.hi |=> q.ool)
    else $error("high limit violation not flagged");

  limit_low_a: assert property (latch && latch_val < q.lo |=> q.ool)
    else $error("low limit violation not flagged");

  flag_hold_a: assert property (q.ool && !clr_ool |=> q.ool)
    else $error("limit flag dropped without a clear");

  limit_irq_a: assert property (q.ool |-> IRQ)
    else $error("limit flag without interrupt");

  ready_irq_a: assert property (q.cr && q.cr_ie |-> IRQ)
    else $error("count ready without interrupt");

  irq_source_a: assert property (IRQ |-> q.ool || (q.cr && q.cr_ie) || (q.tg && q.tg_ie))
    else $error("interrupt without a status event");

  sleep_halt_a: assert property (SLEEP_REQ |=> q.st == fan_monitor_pkg::MEAS_IDLE)
    else $error("sleep request did not halt measurement");

  sleep_ack_a: assert property (SLEEP_REQ |=> SLEEP_ACK)
    else $error("sleep request not acknowledged");

  count_hold_a: assert property (!run |=> q.cnt == $past(q.cnt))
    else $error("counter moved while halted");

  reset_state_a: assert property ($past(SYS_RST) |->
    q.cnt == 16'h0000 && !IRQ && q.hi == 16'hFFFF)
    else $error("block not at defaults after reset");

endmodule : fan_speed_monitor

// ---- bench/fan_model.sv ----
// Behavioural fan giving a 50% duty tach square wave
`timescale 1ns/1ps
module fan_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] half,
  output logic             tach
);
  logic [15:0] cnt_q;
  initial begin
    tach  = 1'b0;
    cnt_q = 16'h0000;
  end
  // Stopped fan holds its last level, as a stalled rotor does
  always @(posedge clk) begin
    if (!run) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= half) begin
      cnt_q <= 16'h0000;
      tach  <= ~tach;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : fan_model

// ---- bench/fan_speed_monitor_tb_top.sv ----
// Self-checking bench for the fan speed monitor
`timescale 1ns/1ps
module fan_speed_monitor_tb_top;
  localparam int unsigned DIV  = 4;
  localparam logic [15:0] HALF = 16'h0028;
  logic        mclk      = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic        fan_run   = 1'b0;
  logic        sleep_req = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tach;
  logic        sleep_ack;
  logic        irq;
  logic [31:0] rdata;
  logic [31:0] cfg;
  logic        rerr;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          rises = 0;
  int          nedge;
  int          exp_cnt;
  logic [15:0] hi_tab [3] = '{16'h0005, 16'hFFFF, 16'h0014};
  logic [15:0] lo_tab [3] = '{16'h0000, 16'h0014, 16'h0000};
  logic        ool_tab [3] = '{1'b1, 1'b1, 1'b0};

  fan_speed_monitor #(.TICK_DIV(DIV)) uut (
    .MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FAN_SPEED_IN(tach),
    .SLEEP_REQ(sleep_req), .SLEEP_ACK(sleep_ack), .IRQ(irq)
  );
  fan_model fan (.clk(mclk), .run(fan_run), .half(HALF), .tach(tach));

  always #5 mclk = ~mclk;
  always @(posedge tach) rises++;

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Slave answer time is not assumed; the wait runs until PREADY, bounded only by the timeout
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll_cr();
    int n;
    n = 0;
    do begin
      apb(1'b0, fan_monitor_pkg::STAT_OFF, 32'h0000_0000);
      n++;
    end while (rdata[3] !== 1'b1 && n < 200);
  endtask : poll_cr

  task automatic halt();
    apb(1'b1, fan_monitor_pkg::CTRL_OFF, 32'h0000_0000);
    fan_run <= 1'b0;
    apb(1'b1, fan_monitor_pkg::STAT_OFF, 32'h0000_000F);
    // Line drops with the cleared flags on the edge where the write lands
    @(posedge mclk);
    chk(irq, 1'b0);
  endtask : halt

  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    apb(1'b0, fan_monitor_pkg::CTRL_OFF, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    apb(1'b0, fan_monitor_pkg::STAT_OFF, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    apb(1'b0, fan_monitor_pkg::HIGH_OFF, 32'h0000_0000);
    chk(rdata, 32'h0000_FFFF);
    apb(1'b0, fan_monitor_pkg::LOW_OFF, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    // Free count with interrupts off; pulses taken as a difference of readings
    apb(1'b1, fan_monitor_pkg::CTRL_OFF, 32'h0000_0001);
    apb(1'b0, fan_monitor_pkg::CTRL_OFF, 32'h0000_0000);
    cfg = rdata;
    rises = 0;
    fan_run <= 1'b1;
    repeat (1000) @(posedge mclk);
    fan_run <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b0, fan_monitor_pkg::CTRL_OFF, 32'h0000_0000);
    chk(16'(rdata[31:16] - cfg[31:16]), rises[15:0]);
    apb(1'b0, fan_monitor_pkg::STAT_OFF, 32'h0000_0000);
    chk(rdata[2], tach);
    chk(rdata[1], 1'b1);
    // Toggle enable alone then raises the line from the sticky flag
    apb(1'b1, fan_monitor_pkg::CTRL_OFF, 32'h0000_8001);
    @(posedge mclk);
    chk(irq, 1'b1);
    halt();
    // Every edge code, five edges being the usual two-period fan
    for (int s = 0; s < 4; s++) begin
      nedge = (s == 0) ? 2 : (s == 1) ? 3 : (s == 2) ? 5 : 9;
      exp_cnt = (nedge - 1) * int'(HALF) / DIV;
      cfg = 32'h0000_4003 | (32'(s) << 11);
      apb(1'b1, fan_monitor_pkg::CTRL_OFF, cfg);
      fan_run <= 1'b1;
      apb(1'b1, fan_monitor_pkg::STAT_OFF, 32'h0000_000F);
      poll_cr();
      chk(rdata[3], 1'b1);
      chk(irq, 1'b1);
      apb(1'b0, fan_monitor_pkg::CTRL_OFF, 32'h0000_0000);
      cmp_count++;
      // Tick phase against the edges allows one count either way
      if (int'(rdata[31:16]) < exp_cnt - 1 || int'(rdata[31:16]) > exp_cnt + 1) begin
        error_cnt++;
        $display("BAD t=%0t got=%h exp=%h", $time, rdata[31:16], exp_cnt);
      end
      halt();
    end
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, fan_monitor_pkg::HIGH_OFF, {16'h0000, hi_tab[k]});
      apb(1'b1, fan_monitor_pkg::LOW_OFF, {16'h0000, lo_tab[k]});
      apb(1'b1, fan_monitor_pkg::CTRL_OFF, 32'h0000_0003);
      fan_run <= 1'b1;
      apb(1'b1, fan_monitor_pkg::STAT_OFF, 32'h0000_000F);
      poll_cr();
      chk(rdata[0], ool_tab[k]);
      chk(irq, ool_tab[k]);
      halt();
    end
    // Low-power request freezes measurement
    apb(1'b1, fan_monitor_pkg::CTRL_OFF, 32'h0000_0003);
    fan_run   <= 1'b1;
    sleep_req <= 1'b1;
    for (int i = 0; i < 50 && sleep_ack !== 1'b1; i++) @(posedge mclk);
    chk(sleep_ack, 1'b1);
    apb(1'b1, fan_monitor_pkg::STAT_OFF, 32'h0000_000F);
    repeat (300) @(posedge mclk);
    apb(1'b0, fan_monitor_pkg::STAT_OFF, 32'h0000_0000);
    chk(rdata[3], 1'b0);
    sleep_req <= 1'b0;
    poll_cr();
    chk(rdata[3], 1'b1);
    halt();
    // Reset in mid-run brings every register back to its default
    apb(1'b1, fan_monitor_pkg::HIGH_OFF, 32'h0000_1234);
    apb(1'b1, fan_monitor_pkg::CTRL_OFF, 32'h0000_C803);
    fan_run <= 1'b1;
    repeat (200) @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    fan_run <= 1'b0;
    @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b0, fan_monitor_pkg::CTRL_OFF, 32'h0000_0000);
    chk(rdata, 32'h0000_0000);
    apb(1'b0, fan_monitor_pkg::HIGH_OFF, 32'h0000_0000);
    chk(rdata, 32'h0000_FFFF);
    wrap_up();
  end
endmodule : fan_speed_monitor_tb_top
